//--- hw/agd_group_decoder.v
/*
 Arithmetic group decoder: sizes groups from their slots, assigns units,
 checks indexing, keeps the index register and previous results.
 Assumes one slot per cycle from the sequencer and results per group
 returned by the execution units after the group is issued.
*/
// The register addresses and the address-and-strobe port were decided locally.
// Operation
// RULE_01: Accept groups of one to seven 64-bit slots.
// RULE_02: Group ends at the instruction with its end flag; literals carry none.
// RULE_03: Program orders slots x,y,z,w,trans; at most four omitted.
// RULE_04: Program gives first literal slot, or both; never second alone.
// RULE_05: Program puts a transcendental-unit instruction last in its group.
// RULE_06: Trans-only goes to trans unit; vector-only to its destination element.
// RULE_07: Ambiguous goes to trans if element taken or final under policy.
// RULE_08: Host-only policy bit, clear by default sends ambiguous finals to vector.
// RULE_09: Second assignment to an allocated unit is an error.
// RULE_10: Unallocated units run a no-operation, invalidating their previous result.
// RULE_11: Two-source opcode has top three bits zero; three-source has some nonzero.
// RULE_12: Two-source format up to two sources; three-source for three.
// RULE_13: Up to 127 general and 256 constant registers per clause.
// RULE_14: Top N general registers are clause temporaries when N above zero.
// RULE_15: Constants offset by loop or any index element; general by x or loop.
// RULE_16: Two locked constant-cache banks of 16 entries held for the clause.
// RULE_17: One index per instruction; each operand flag selects relative use.
// RULE_18: Index modes offset general by x, constants by element; loop for all.
// RULE_19: Index register must be loaded in an earlier group of the clause.
// RULE_20: No index-register use in a group holding an index load.
// RULE_21: All slots of a group use the same index element.
// RULE_22: Cached constants are relative only through the loop counter.
// RULE_23: No relative indexing of clause temporaries.
// RULE_24: Keep four element results and the trans result of the prior group.
// RULE_25: Previous results die on no-operation and at clause end.
// RULE_26: Raise illegal-group error on any assignment or indexing violation.
// RULE_27: Index register invalidated at each clause end.
`timescale 1ns/1ps
`include "agd_defines.vh"
module agd_group_decoder (
    input wire ref_clk,
    input wire rst,
    input wire [7:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [31:0] regRdData,
    input wire clauseStart,
    input wire clauseEnd,
    input wire [7:0] loopIdx,
    input wire slotValid,
    input wire [63:0] slotData,
    input wire arLoad,
    input wire [31:0] arLoadData,
    input wire resValid,
    input wire [127:0] resVector,
    input wire [31:0] resScalar,
    output reg instValid,
    output reg [2:0] instUnit,
    output reg [2:0] instSlot,
    output reg instOp3,
    output reg [6:0] instOpcode,
    output reg [35:0] instSrcs,
    output reg [6:0] instDst,
    output reg litValid,
    output reg [63:0] litData,
    output reg groupDone,
    output reg [4:0] groupUnits,
    output reg [2:0] groupSlots,
    output reg illegalGroup,
    output reg arValid,
    output reg [3:0] pvValid,
    output reg psValid,
    output reg [127:0] prevVector,
    output reg [31:0] prevScalar
);
    localparam S_INST = 1'b0;
    localparam S_LIT = 1'b1;

    reg state_r;
    reg [2:0] slotCnt_r;
    reg [2:0] instCnt_r;
    reg [4:0] alloc_r;
    reg [1:0] litNeed_r;
    reg [1:0] litLeft_r;
    reg grpErr_r;
    reg grpAr_r;
    reg grpMova_r;
    reg [1:0] grpArElem_r;
    reg [31:0] ar_r;
    reg policy_r;
    reg [3:0] tempCnt_r;
    reg errSticky_r;
    reg [4:0] lastUnits_r;
    reg [31:0] rdData_nxt;
    integer e;

    wire isLast;
    wire isOp3;
    wire [6:0] opcode;
    wire transOnly;
    wire vectorOnly;
    wire isMova;
    wire [1:0] dstElem;
    wire [1:0] litUse;
    wire usesAr;
    wire [1:0] arElem;
    wire errKcAr;
    wire errTempRel;
    wire [35:0] srcs;
    wire [6:0] dstAddr;

    agd_slot_decode u_dec (
        .slot(slotData),
        .arVec(ar_r),
        .loopIdx(loopIdx),
        .tempCount(tempCnt_r),
        .isLast(isLast),
        .isOp3(isOp3),
        .opcode(opcode),
        .transOnly(transOnly),
        .vectorOnly(vectorOnly),
        .isMova(isMova),
        .dstElem(dstElem),
        .litUse(litUse),
        .usesAr(usesAr),
        .arElem(arElem),
        .errKcAr(errKcAr),
        .errTempRel(errTempRel),
        .srcs(srcs),
        .dstAddr(dstAddr)
    );

    // Unit choice; decided per slot since the end flag sits in the word itself
    wire elemTaken = alloc_r[dstElem];
    wire ambig = ~transOnly & ~vectorOnly;
    wire toTrans = transOnly | (ambig & (elemTaken | (policy_r & isLast))); // RULE_06 RULE_07 RULE_08
    wire [2:0] unit = toTrans ? `AGD_UNIT_T : {1'b0, dstElem};
    wire dup = alloc_r[unit]; // RULE_09
    wire arErr = usesAr & (~arValid | (grpAr_r & (grpArElem_r != arElem))); // RULE_19 RULE_21
    wire instErr = dup | arErr | errKcAr | errTempRel; // RULE_22 RULE_23
    // A fifth instruction without the end flag would overrun seven slots
    wire forceEnd = (instCnt_r == (`AGD_MAX_INST - 3'h1)) & ~isLast; // RULE_01
    wire takeInst = slotValid & (state_r == S_INST);
    wire takeLit = slotValid & (state_r == S_LIT);
    wire [1:0] needNow = (litUse > litNeed_r) ? litUse : litNeed_r;
    wire instEnds = takeInst & (isLast | forceEnd); // RULE_02
    wire commit = (instEnds & (needNow == 2'h0)) | (takeLit & (litLeft_r == 2'h1));
    wire [4:0] allocN = alloc_r | (takeInst ? (5'h01 << unit) : 5'h00);
    wire grpMovaN = grpMova_r | (takeInst & isMova);
    wire grpArN = grpAr_r | (takeInst & usesAr);
    wire grpErrN = grpErr_r | (takeInst & (instErr | forceEnd));
    wire commitErr = grpErrN | (grpMovaN & grpArN); // RULE_20 RULE_26
    wire clauseClr = clauseStart | clauseEnd;

    // Slot walk: instructions, then the literal slots their operands ask for
    always @(posedge ref_clk) begin
        if (rst || clauseClr) begin
            state_r <= S_INST;
            slotCnt_r <= 3'h0;
            instCnt_r <= 3'h0;
            alloc_r <= 5'h00;
            litNeed_r <= 2'h0;
            litLeft_r <= 2'h0;
            grpErr_r <= 1'b0;
            grpAr_r <= 1'b0;
            grpMova_r <= 1'b0;
            grpArElem_r <= 2'h0;
        end else if (commit) begin
            state_r <= S_INST;
            slotCnt_r <= 3'h0;
            instCnt_r <= 3'h0;
            alloc_r <= 5'h00;
            litNeed_r <= 2'h0;
            litLeft_r <= 2'h0;
            grpErr_r <= 1'b0;
            grpAr_r <= 1'b0;
            grpMova_r <= 1'b0;
            grpArElem_r <= 2'h0;
        end else if (slotValid) begin
            slotCnt_r <= slotCnt_r + 3'h1;
            case (state_r)
                S_INST: begin
                    instCnt_r <= instCnt_r + 3'h1;
                    alloc_r <= allocN;
                    litNeed_r <= needNow;
                    grpErr_r <= grpErrN;
                    grpAr_r <= grpArN;
                    grpMova_r <= grpMovaN;
                    if (usesAr && !grpAr_r)
                        grpArElem_r <= arElem;
                    if (instEnds) begin
                        state_r <= S_LIT; // RULE_04
                        litLeft_r <= needNow;
                    end
                end
                S_LIT: begin
                    litLeft_r <= litLeft_r - 2'h1;
                end
                default: begin
                    state_r <= S_INST;
                end
            endcase
        end
    end

    // Issue outputs, one cycle after the slot is taken
    always @(posedge ref_clk) begin
        if (rst) begin
            instValid <= 1'b0;
            instUnit <= 3'h0;
            instSlot <= 3'h0;
            instOp3 <= 1'b0;
            instOpcode <= 7'h00;
            instSrcs <= 36'h000000000;
            instDst <= 7'h00;
            litValid <= 1'b0;
            litData <= 64'h0000000000000000;
            groupDone <= 1'b0;
            groupUnits <= 5'h00;
            groupSlots <= 3'h0;
            illegalGroup <= 1'b0;
        end else begin
            instValid <= takeInst & ~clauseClr;
            litValid <= takeLit & ~clauseClr;
            groupDone <= commit & ~clauseClr;
            illegalGroup <= commit & ~clauseClr & commitErr; // RULE_26
            if (takeInst) begin
                instUnit <= unit;
                instSlot <= slotCnt_r;
                instOp3 <= isOp3; // RULE_12
                instOpcode <= opcode;
                instSrcs <= srcs;
                instDst <= dstAddr;
            end
            if (takeLit)
                litData <= slotData;
            if (commit) begin
                groupUnits <= allocN; // RULE_10
                groupSlots <= slotCnt_r + 3'h1;
            end
        end
    end

    // Index register; only an index load writes it, so first-group use is caught
    always @(posedge ref_clk) begin
        if (rst || clauseClr) begin
            arValid <= 1'b0; // RULE_27
            ar_r <= 32'h00000000;
        end else if (arLoad) begin
            arValid <= 1'b1;
            ar_r <= arLoadData;
        end
    end

    // Units used by the last group, so returned results know which to keep
    always @(posedge ref_clk) begin
        if (rst || clauseClr)
            lastUnits_r <= 5'h00;
        else if (commit)
            lastUnits_r <= allocN;
    end

    // Previous results; a unit that ran a no-operation loses its entry
    always @(posedge ref_clk) begin
        if (rst || clauseClr) begin
            pvValid <= 4'h0; // RULE_25
            psValid <= 1'b0;
            prevVector <= 128'h0;
            prevScalar <= 32'h00000000;
        end else if (resValid) begin
            for (e = 0; e < 4; e = e + 1) begin
                pvValid[e] <= lastUnits_r[e]; // RULE_10 RULE_24
                if (lastUnits_r[e])
                    prevVector[32*e +: 32] <= resVector[32*e +: 32];
            end
            psValid <= lastUnits_r[4];
            if (lastUnits_r[4])
                prevScalar <= resScalar; // RULE_24
        end
    end

    // Host-side config; policy and temporary count only change here
    always @(posedge ref_clk) begin
        if (rst) begin
            policy_r <= |(`AGD_CFG_RESET & (32'h00000001 << `AGD_CFG_POLICY_BIT));
            tempCnt_r <= 4'h0;
        end else if (regWr && regAddr == `AGD_REG_CFG) begin
            policy_r <= regWrData[`AGD_CFG_POLICY_BIT]; // RULE_08
            tempCnt_r <= regWrData[`AGD_CFG_TEMP_MSB:`AGD_CFG_TEMP_LSB]; // RULE_14
        end
    end

    // Sticky error; a new error in the clearing cycle wins
    always @(posedge ref_clk) begin
        if (rst)
            errSticky_r <= 1'b0;
        else if (commit && commitErr && !clauseClr)
            errSticky_r <= 1'b1;
        else if (regWr && regAddr == `AGD_REG_STATUS && regWrData[`AGD_STATUS_ERR_BIT])
            errSticky_r <= 1'b0;
    end

    // Read mux; unmapped offsets read as zero
    always @* begin
        rdData_nxt = 32'h00000000;
        case (regAddr)
            `AGD_REG_CFG: rdData_nxt = {20'h00000, tempCnt_r, 7'h00, policy_r};
            `AGD_REG_STATUS: rdData_nxt = {16'h0000, 3'h0, lastUnits_r, pvValid, psValid,
                state_r, arValid, errSticky_r};
            `AGD_REG_PS: rdData_nxt = prevScalar;
            `AGD_REG_PV0: rdData_nxt = prevVector[31:0];
            `AGD_REG_PV1: rdData_nxt = prevVector[63:32];
            `AGD_REG_PV2: rdData_nxt = prevVector[95:64];
            `AGD_REG_PV3: rdData_nxt = prevVector[127:96];
            default: rdData_nxt = 32'h00000000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rst)
            regRdData <= 32'h00000000;
        else
            regRdData <= regRd ? rdData_nxt : 32'h00000000;
    end
endmodule

//--- hw/agd_defines.vh
/*
 Constants for the arithmetic group decoder: register offsets, config
 fields, instruction word fields, operand select ranges and unit codes.
 Assumes it is included by bare name from every design file.
*/
`ifndef AGD_DEFINES_VH
`define AGD_DEFINES_VH
// Register byte offsets
`define AGD_REG_CFG 8'h00
`define AGD_REG_STATUS 8'h04
`define AGD_REG_PS 8'h08
`define AGD_REG_PV0 8'h0C
`define AGD_REG_PV1 8'h10
`define AGD_REG_PV2 8'h14
`define AGD_REG_PV3 8'h18
// Config fields and reset value
`define AGD_CFG_POLICY_BIT 0
`define AGD_CFG_TEMP_LSB 8
`define AGD_CFG_TEMP_MSB 11
`define AGD_CFG_RESET 32'h00000000
`define AGD_STATUS_ERR_BIT 0
// Instruction fields, low word
`define AGD_F_SRC0_SEL 8:0
`define AGD_F_SRC0_REL 9
`define AGD_F_SRC0_ELEM 11:10
`define AGD_F_SRC1_SEL 20:12
`define AGD_F_SRC1_REL 21
`define AGD_F_SRC1_ELEM 23:22
`define AGD_F_INDEX_MODE 26:24
`define AGD_F_LAST 31
// Instruction fields, high word
`define AGD_F_SRC2_SEL 40:32
`define AGD_F_SRC2_REL 41
`define AGD_F_SRC2_ELEM 43:42
`define AGD_F_OPCODE 53:44
`define AGD_F_DST_GPR 60:54
`define AGD_F_DEST_RELATIVE_FLAG 61
`define AGD_F_DST_ELEM 63:62
// Operand select ranges
`define AGD_SEL_KC0_BASE 9'h080
`define AGD_SEL_KC1_BASE 9'h090
`define AGD_SEL_KC_END 9'h0A0
`define AGD_SEL_CFILE_BASE 9'h100
`define AGD_SEL_LITERAL 9'h0FD
// Index modes
`define AGD_IDX_LOOP 3'h4
// Operand kinds
`define AGD_K_GPR 3'h0
`define AGD_K_KC0 3'h1
`define AGD_K_KC1 3'h2
`define AGD_K_CONST 3'h3
`define AGD_K_LIT 3'h4
`define AGD_K_OTHER 3'h5
// Unit codes, x..w are 0..3
`define AGD_UNIT_T 3'h4
// Opcode classes of the two-source format
`define AGD_OP_TRANS_LO 7'h60
`define AGD_OP_TRANS_HI 7'h7F
`define AGD_OP_VEC_LO 7'h50
`define AGD_OP_VEC_HI 7'h5F
`define AGD_OP_INDEX_LOAD_INSTRUCTION_LO 7'h14
`define AGD_OP_INDEX_LOAD_INSTRUCTION_HI 7'h17
// Group limits
`define AGD_MAX_INST 3'h5
`define AGD_IDX_W 8
`endif

//--- hw/agd_slot_decode.v
/*
 Combinational decode of one 64-bit instruction slot: format, opcode class,
 destination element, literal use, index use and resolved operand addresses.
 Assumes the index register and loop counter are stable during the slot.
*/
`timescale 1ns/1ps
`include "agd_defines.vh"
module agd_slot_decode (
    input wire [63:0] slot,
    input wire [31:0] arVec,
    input wire [7:0] loopIdx,
    input wire [3:0] tempCount,
    output wire isLast,
    output wire isOp3,
    output wire [6:0] opcode,
    output wire transOnly,
    output wire vectorOnly,
    output wire isMova,
    output wire [1:0] dstElem,
    output wire [1:0] litUse,
    output wire usesAr,
    output wire [1:0] arElem,
    output wire errKcAr,
    output wire errTempRel,
    output wire [35:0] srcs,
    output wire [6:0] dstAddr
);
    wire [9:0] opField = slot[`AGD_F_OPCODE];
    wire [2:0] mode = slot[`AGD_F_INDEX_MODE];
    wire loopMode = (mode == `AGD_IDX_LOOP);
    wire [7:0] gprIdx = loopMode ? loopIdx : arVec[7:0];
    wire [6:0] tempBase = 7'h7F - {3'h0, tempCount} + 7'h01;
    wire rel0 = slot[`AGD_F_SRC0_REL];
    wire rel1 = slot[`AGD_F_SRC1_REL];
    wire rel2 = slot[`AGD_F_SRC2_REL] & isOp3;
    wire relDst = slot[`AGD_F_DEST_RELATIVE_FLAG];

    // Operand kind from its select value
    function [2:0] kindOf(input [8:0] sel);
        begin
            if (sel[8])
                kindOf = `AGD_K_CONST;
            else if (sel < `AGD_SEL_KC0_BASE)
                kindOf = `AGD_K_GPR;
            else if (sel < `AGD_SEL_KC1_BASE)
                kindOf = `AGD_K_KC0;
            else if (sel < `AGD_SEL_KC_END)
                kindOf = `AGD_K_KC1;
            else if (sel == `AGD_SEL_LITERAL)
                kindOf = `AGD_K_LIT;
            else
                kindOf = `AGD_K_OTHER;
        end
    endfunction

    // Kind and resolved address; kcache is only ever offset by the loop counter
    function [11:0] resolve(input [8:0] sel, input rel);
        reg [2:0] k;
        reg [7:0] cIdx;
        begin
            k = kindOf(sel);
            cIdx = loopMode ? loopIdx : arVec[8*mode[1:0] +: 8];
            case (k)
                `AGD_K_GPR: resolve = {k, 2'h0, sel[6:0] + (rel ? gprIdx[6:0] : 7'h00)}; // RULE_18
                `AGD_K_CONST: resolve = {k, 1'b0, sel[7:0] + (rel ? cIdx : 8'h00)}; // RULE_15
                `AGD_K_KC0, `AGD_K_KC1: // RULE_16
                    resolve = {k, 5'h00, sel[3:0] + ((rel & loopMode) ? loopIdx[3:0] : 4'h0)};
                default: resolve = {k, sel};
            endcase
        end
    endfunction

    // Operand reaches a clause temporary with a relative index
    function tempRel(input [8:0] sel, input rel);
        begin
            tempRel = rel && (kindOf(sel) == `AGD_K_GPR) && (tempCount != 4'h0) &&
                (sel[6:0] >= tempBase);
        end
    endfunction

    // Literal slots needed by one operand: one for x,y, two for z,w
    function [1:0] litOf(input [8:0] sel, input [1:0] elem);
        begin
            litOf = (sel != `AGD_SEL_LITERAL) ? 2'h0 : (elem[1] ? 2'h2 : 2'h1);
        end
    endfunction

    function [1:0] max2(input [1:0] a, input [1:0] b);
        begin
            max2 = (a > b) ? a : b;
        end
    endfunction

    function kcRel(input [8:0] sel, input rel);
        begin
            kcRel = rel && ((kindOf(sel) == `AGD_K_KC0) || (kindOf(sel) == `AGD_K_KC1));
        end
    endfunction

    assign isLast = slot[`AGD_F_LAST]; // RULE_02
    assign isOp3 = (opField[9:7] != 3'h0); // RULE_11 RULE_12
    assign opcode = isOp3 ? {2'h0, opField[9:5]} : opField[6:0]; // RULE_11
    assign transOnly = ~isOp3 && (opcode >= `AGD_OP_TRANS_LO) && (opcode <= `AGD_OP_TRANS_HI);
    assign vectorOnly = ~isOp3 && (opcode >= `AGD_OP_VEC_LO) && (opcode <= `AGD_OP_VEC_HI);
    assign isMova = ~isOp3 && (opcode >= `AGD_OP_INDEX_LOAD_INSTRUCTION_LO) && (opcode <= `AGD_OP_INDEX_LOAD_INSTRUCTION_HI);
    assign dstElem = slot[`AGD_F_DST_ELEM];
    assign litUse = max2(max2(litOf(slot[`AGD_F_SRC0_SEL], slot[`AGD_F_SRC0_ELEM]),
        litOf(slot[`AGD_F_SRC1_SEL], slot[`AGD_F_SRC1_ELEM])),
        isOp3 ? litOf(slot[`AGD_F_SRC2_SEL], slot[`AGD_F_SRC2_ELEM]) : 2'h0);
    // One common index per instruction, each operand opts in
    assign usesAr = ~loopMode && (rel0 | rel1 | rel2 | relDst); // RULE_17
    assign arElem = mode[1:0];
    assign errKcAr = ~loopMode && (kcRel(slot[`AGD_F_SRC0_SEL], rel0) |
        kcRel(slot[`AGD_F_SRC1_SEL], rel1) | kcRel(slot[`AGD_F_SRC2_SEL], rel2)); // RULE_18
    assign errTempRel = tempRel(slot[`AGD_F_SRC0_SEL], rel0) |
        tempRel(slot[`AGD_F_SRC1_SEL], rel1) | tempRel(slot[`AGD_F_SRC2_SEL], rel2) |
        tempRel({2'h0, slot[`AGD_F_DST_GPR]}, relDst); // RULE_14
    assign srcs = {isOp3 ? resolve(slot[`AGD_F_SRC2_SEL], rel2) : {`AGD_K_OTHER, 9'h000},
        resolve(slot[`AGD_F_SRC1_SEL], rel1), resolve(slot[`AGD_F_SRC0_SEL], rel0)};
    assign dstAddr = slot[`AGD_F_DST_GPR] + (relDst ? gprIdx[6:0] : 7'h00); // RULE_13
endmodule

//--- tb/agd_group_decoder_sva.sv
/*
 Port checker for the arithmetic group decoder.
 Assumes it is bound to agd_group_decoder: one clock, synchronous reset.
*/
`timescale 1ns/1ps
`include "agd_defines.vh"
module agd_group_decoder_sva (
    input wire ref_clk,
    input wire rst,
    input wire regRd,
    input wire [31:0] regRdData,
    input wire slotValid,
    input wire [63:0] slotData,
    input wire clauseStart,
    input wire clauseEnd,
    input wire arLoad,
    input wire resValid,
    input wire instValid,
    input wire [2:0] instUnit,
    input wire instOp3,
    input wire [6:0] instOpcode,
    input wire litValid,
    input wire groupDone,
    input wire [4:0] groupUnits,
    input wire [2:0] groupSlots,
    input wire illegalGroup,
    input wire arValid,
    input wire [3:0] pvValid,
    input wire psValid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Clause boundary with nothing competing, then index and previous-result valids clear
    sequence s_bound;
        (clauseStart || clauseEnd) && !arLoad && !resValid;
    endsequence
    sequence s_wiped;
        !arValid && pvValid == 4'h0 && !psValid;
    endsequence
    chk_issue_follows_slot: assert property ((instValid || litValid) |-> $past(slotValid))
        else $error("stray issue");
    chk_group_size: assert property (groupDone |-> groupSlots != 3'h0 && $past(slotValid))
        else $error("empty group");
    chk_trans_only: assert property (instValid && !instOp3 && instOpcode >= `AGD_OP_TRANS_LO |-> instUnit == `AGD_UNIT_T)
        else $error("trans unit");
    chk_vec_elem: assert property (instValid && !instOp3 && instOpcode >= `AGD_OP_VEC_LO && instOpcode <= `AGD_OP_VEC_HI |-> instUnit == {1'b0, $past(slotData[63:62])})
        else $error("vector unit");
    chk_format_bits: assert property (instValid |-> instOp3 == ($past(slotData[53:51]) != 3'h0))
        else $error("format");
    chk_err_with_done: assert property (illegalGroup |-> groupDone)
        else $error("stray error");
    chk_nop_scalar: assert property (groupDone && !groupUnits[4] |-> ##[0:2] !psValid)
        else $error("scalar kept");
    chk_clause_wipe: assert property (s_bound |=> s_wiped)
        else $error("clause state");
    chk_index_load: assert property (arLoad && !clauseStart && !clauseEnd |=> arValid)
        else $error("index load");
    chk_pv_cause: assert property ($rose(pvValid[0]) |-> $past(resValid))
        else $error("stray result");
    chk_read_slot: assert property (regRdData != 32'h0 |-> $past(regRd))
        else $error("stray read");
endmodule
bind agd_group_decoder agd_group_decoder_sva agd_group_decoder_sva_i (.*);

//--- tb/agd_seq_model.sv
/*
 Sequencer and execution-unit stand-in.
 Assumes the bench orders slots legally unless testing errors.
*/
`timescale 1ns/1ps
module agd_seq_model (
    input wire ref_clk,
    input wire groupDone,
    output logic slotValid,
    output logic [63:0] slotData,
    output logic resValid,
    output logic [127:0] resVector,
    output logic [31:0] resScalar
);
    localparam logic [127:0] RV = 128'h44444444_33333333_22222222_11111111;
    localparam logic [31:0] RS = 32'h5A5A0F0F;
    initial begin
        slotValid = 1'b0;
        slotData = 64'h0;
    end
    // One slot per call; order, literals and index use come from the caller
    task send(input [63:0] s);
        @(posedge ref_clk);
        slotValid <= 1'b1;
        slotData <= s;
        @(posedge ref_clk);
        slotValid <= 1'b0;
        slotData <= ~s; // Idle bus must not echo the last slot
    endtask
    // Results one cycle after each group; garbage when idle
    always @(posedge ref_clk) begin
        resValid <= groupDone;
        resVector <= groupDone ? RV : ~RV;
        resScalar <= groupDone ? RS : ~RS;
    end
endmodule

//--- tb/agd_group_decoder_tb_top.sv
/*
 Self-checking bench for the group decoder.
 Assumes the sequencer model on the slot side.
*/
`timescale 1ns/1ps
`include "agd_defines.vh"
module agd_group_decoder_tb_top;
    logic ref_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic clauseStart = 1'b0, clauseEnd = 1'b0, arLoad = 1'b0;
    logic [7:0] regAddr = 8'h00, loopIdx = 8'h00;
    logic [31:0] regWrData = 32'h0, arLoadData = 32'h0;
    wire slotValid, resValid, instValid, instOp3, litValid, groupDone, illegalGroup;
    wire arValid, psValid;
    wire [63:0] slotData, litData;
    wire [127:0] resVector, prevVector;
    wire [31:0] resScalar, regRdData, prevScalar;
    wire [2:0] instUnit, instSlot, groupSlots;
    wire [6:0] instOpcode, instDst;
    wire [35:0] instSrcs;
    wire [4:0] groupUnits;
    wire [3:0] pvValid;
    integer mismatches = 0, num_checks = 0, i;
    agd_group_decoder agd_group_decoder_i (.*);
    agd_seq_model seq_i (.ref_clk, .groupDone, .slotValid, .slotData, .resValid, .resVector,
        .resScalar);
    // 25 ns period
    always #12.5 ref_clk = ~ref_clk;
    task chk(input string n, input [191:0] g, input [191:0] e);
        num_checks = num_checks + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Register bus, read data checked in the cycle after
    task wr(input [7:0] a, input [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task rd(input [7:0] a, input [31:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 chk("regRdData", regRdData, e);
    endtask
    task clause(input e);
        @(posedge ref_clk);
        clauseStart <= !e;
        clauseEnd <= e;
        @(posedge ref_clk);
        clauseStart <= 1'b0;
        clauseEnd <= 1'b0;
    endtask
    function automatic [63:0] mk(input [9:0] op, input [1:0] de, input lst, input [8:0] s0 = 9'h0,
        input r0 = 1'b0, input [2:0] im = 3'h0);
        mk = {de, 8'h00, op, 12'h000, lst, 4'h0, im, 14'h0000, r0, s0};
    endfunction
    // Send a slot and judge the unit it landed on
    task sc(input [63:0] s, input [2:0] u);
        seq_i.send(s);
        #1 chk("instValid", instValid, 1'b1);
        chk("instUnit", instUnit, u);
    endtask
    task err(input [63:0] s, input e);
        seq_i.send(s);
        #1 chk("illegalGroup", illegalGroup, e);
    endtask
    task t_regs;
        rd(`AGD_REG_CFG, 32'h0);
        wr(`AGD_REG_CFG, 32'h1);
        rd(`AGD_REG_CFG, 32'h1);
        rd(8'h40, 32'h0);
        wr(`AGD_REG_CFG, 32'h0);
        $display("t_regs done");
    endtask
    task t_assign;
        clause(1'b0);
        sc(mk(10'h050, 2'h0, 1'b0), 3'h0);
        sc(mk(10'h000, 2'h0, 1'b1), `AGD_UNIT_T);
        chk("groupUnits", groupUnits, 5'h11);
        chk("instOp3", instOp3, 1'b0);
        sc(mk(10'h000, 2'h1, 1'b1), 3'h1);
        wr(`AGD_REG_CFG, 32'h1);
        sc(mk(10'h000, 2'h1, 1'b1), `AGD_UNIT_T);
        wr(`AGD_REG_CFG, 32'h0);
        sc(mk(10'h060, 2'h3, 1'b1), `AGD_UNIT_T);
        sc(mk(10'h200, 2'h2, 1'b1), 3'h2);
        chk("instOp3", instOp3, 1'b1);
        err(mk(10'h050, 2'h2, 1'b0), 1'b0);
        err(mk(10'h050, 2'h2, 1'b1), 1'b1);
        $display("t_assign done");
    endtask
    // Seven-slot group: four elements, trans, two literal slots
    task t_full;
        clause(1'b0);
        for (i = 0; i < 4; i = i + 1)
            sc(mk(10'h050, i, 1'b0, (i == 2) ? `AGD_SEL_LITERAL : 9'h0)
                | ((i == 2) ? 64'h800 : 64'h0), i);
        sc(mk(10'h060, 2'h0, 1'b1), `AGD_UNIT_T);
        chk("instSlot", instSlot, 3'h4);
        seq_i.send(64'h0123456789ABCDEF);
        #1 chk("litData", {litValid, litData}, {1'b1, 64'h0123456789ABCDEF});
        seq_i.send(64'hFEDCBA9876543210);
        #1 chk("groupSlots", {groupDone, groupSlots}, 4'hF);
        chk("groupUnits", groupUnits, 5'h1F);
        repeat (4) @(posedge ref_clk);
        #1 chk("prevVector", {pvValid, psValid, prevVector, prevScalar}, {5'h1F, seq_i.RV,
            seq_i.RS});
        sc(mk(10'h050, 2'h0, 1'b1), 3'h0);
        repeat (4) @(posedge ref_clk);
        #1 chk("pvValid", {pvValid, psValid}, 5'h02);
        clause(1'b1);
        #1 chk("pvValid", {pvValid, psValid}, 5'h00);
        $display("t_full done");
    endtask
    task t_index;
        clause(1'b0);
        err(mk(10'h050, 2'h0, 1'b1, 9'h3, 1'b1), 1'b1);
        @(posedge ref_clk);
        arLoad <= 1'b1;
        arLoadData <= 32'h00001005;
        @(posedge ref_clk);
        arLoad <= 1'b0;
        loopIdx <= 8'h03;
        for (i = 0; i < 5; i = i + 1) begin
            sc(mk(10'h050, 2'h0, 1'b1, 9'h3, 1'b1, i), 3'h0);
            chk("instSrcs", {instDst, instSrcs[11:0]},
                {7'h00, (i == 4) ? 12'h006 : 12'h008});
        end
        err(mk(10'h050, 2'h0, 1'b1, `AGD_SEL_KC0_BASE, 1'b1), 1'b1);
        err(mk(10'h050, 2'h0, 1'b0, 9'h3, 1'b1), 1'b0);
        err(mk(10'h050, 2'h1, 1'b1, 9'h3, 1'b1, 3'h1), 1'b1);
        wr(`AGD_REG_CFG, 32'h400);
        err(mk(10'h050, 2'h0, 1'b1, 9'h07D, 1'b0, 3'h4), 1'b0);
        err(mk(10'h050, 2'h0, 1'b1, 9'h07D, 1'b1, 3'h4), 1'b1);
        clause(1'b1);
        #1 chk("arValid", arValid, 1'b0);
        $display("t_index done");
    endtask
    // Hang guard, well past the expected run
    initial begin
        #100000;
        mismatches = mismatches + 1;
        close_out;
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs;
        t_assign;
        t_full;
        t_index;
        close_out;
    end
endmodule
